// [hdl/cable_diag_pkg.sv]
// constants, field layout and carriers of the cable diagnostic register bank
// assumes a 32-bit APB master on pclk and engines on the same clock
`default_nettype none
package cable_diag_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int REG_W = 16;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 2;
  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_ACTIVE_LINK_CABLE_TEST = 10'h155;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h170;
  localparam logic [IDX_W-1:0] IDX_PULSE = 10'h171;
  localparam logic [IDX_W-1:0] IDX_LENGTH = 10'h173;
  localparam logic [IDX_W-1:0] IDX_SHORT = 10'h177;
  localparam logic [IDX_W-1:0] IDX_LOC1 = 10'h180;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h1A0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h1A1;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ACTIVE_LINK_CABLE_TEST_START_BIT = 15;
  localparam int ACTIVE_LINK_CABLE_TEST_STATUS_BIT = 12;
  localparam int ACTIVE_LINK_CABLE_TEST_SUM_LSB = 4;
  localparam int ACTIVE_LINK_CABLE_TEST_LOW_LSB = 0;
  localparam int CROSS_DIS_BIT = 14;
  localparam int BYP_TX_BIT = 13;
  localparam int BYP_RX_BIT = 12;
  localparam int AVG_LSB = 8;
  localparam int PULSE_LSB = 0;
  localparam int LEN_LSB = 8;
  localparam int SHORT_LSB = 8;
  localparam int PEAK1_LSB = 0;
  localparam int PEAK2_LSB = 8;
  localparam int IRQ_ACTIVE_LINK_CABLE_TEST_BIT = 0;
  localparam int IRQ_TDR_BIT = 1;
  // ---------------------------------------------------------------
  // reset values and write masks
  // ---------------------------------------------------------------
  localparam logic [7:0] ACTIVE_LINK_CABLE_TEST_SUM_RST = 8'hF4;
  localparam logic [3:0] ACTIVE_LINK_CABLE_TEST_LOW_RST = 4'h1;
  localparam logic [REG_W-1:0] CTRL_RST = 16'h0E52;
  localparam logic [REG_W-1:0] CTRL_WMASK = 16'h7FFF;
  localparam logic [REG_W-1:0] PULSE_RST = 16'hC85C;
  localparam logic [REG_W-1:0] LENGTH_RST = 16'hFF1E;
  localparam logic [REG_W-1:0] SHORT_RST = 16'h189B;
  localparam logic [REG_W-1:0] ALL_WMASK = 16'hFFFF;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [2:0] AVG_MAX_CODE = 3'h6;
  localparam logic [6:0] AVG_MAX_COUNT = 7'h40;

  typedef enum logic {ACTIVE_LINK_CABLE_TEST_IDLE = 1'b0, ACTIVE_LINK_CABLE_TEST_RUN = 1'b1} active_link_cable_test_state_t;

  typedef struct packed {
    logic cross_disable;
    logic bypass_tx;
    logic bypass_rx;
    logic [2:0] avg_code;
    logic [3:0] pulse;
    logic [7:0] listen_len;
    logic [4:0] short_thr;
  } tdr_cfg_t;

  typedef struct packed {
    logic done;
    logic [7:0] sum;
  } active_link_cable_test_result_t;

  typedef struct packed {
    logic done;
    logic [7:0] peak1;
    logic [7:0] peak2;
  } tdr_result_t;
endpackage
`default_nettype wire

// [hdl/cfg_word_reg.sv]
// one software-writable word with byte-lane strobes
// assumes write strobe qualified by the bus slave
`default_nettype none
module cfg_word_reg #(
  parameter logic [15:0] RESET = 16'h0000,
  parameter logic [15:0] WMASK = 16'hFFFF
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic we, // write this cycle
  input wire logic [1:0] strb, // byte lanes
  input wire logic [15:0] wdata, // write data
  output logic [15:0] q // stored word
);
  logic [15:0] next_q;
  logic [15:0] lane;

  always_comb begin
    lane = {{8{strb[1]}}, {8{strb[0]}}} & WMASK;
    next_q = q;
    if (we) begin
      next_q = (q & ~lane) | (wdata & lane);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// [hdl/cable_diag_regs.sv]
// cable diagnostic control and result register bank, APB slave
// assumes engines on pclk drive one-cycle done pulses with result data
`default_nettype none
module cable_diag_regs
  import cable_diag_pkg::*;
(
  input wire logic pclk, // clock, 50 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [DATA_W-1:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic irq, // level interrupt
  output logic active_link_cable_test_start, // active-link test launch pulse
  input wire active_link_cable_test_result_t active_link_cable_test_res, // active-link completion
  input wire tdr_result_t tdr_res, // reflectometry completion
  output tdr_cfg_t tdr_cfg, // reflectometry settings
  output logic [6:0] tdr_avg_count, // cycles to average
  output logic [7:0] active_link_summary_out // active-link summary
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] idx;
  logic setup;
  logic wr;
  logic mapped;
  // zero wait states: every access ends in its first access cycle
  assign idx = paddr[ADDR_W-1:2];
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    unique case (idx)
      IDX_ACTIVE_LINK_CABLE_TEST, IDX_CTRL, IDX_PULSE, IDX_LENGTH, IDX_SHORT, IDX_LOC1, IDX_IRQ_STATUS, IDX_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // configuration words
  // ---------------------------------------------------------------
  logic [REG_W-1:0] ctrl_q;
  logic [REG_W-1:0] pulse_q;
  logic [REG_W-1:0] length_q;
  logic [REG_W-1:0] short_q;
  logic [REG_W-1:0] mask_q;

  cfg_word_reg #(.RESET(CTRL_RST), .WMASK(CTRL_WMASK)) u_ctrl (
    .pclk(pclk), .presetn(presetn), .we(wr && idx == IDX_CTRL),
    .strb(pstrb[1:0]), .wdata(pwdata[REG_W-1:0]), .q(ctrl_q)
  );
  cfg_word_reg #(.RESET(PULSE_RST), .WMASK(ALL_WMASK)) u_pulse (
    .pclk(pclk), .presetn(presetn), .we(wr && idx == IDX_PULSE),
    .strb(pstrb[1:0]), .wdata(pwdata[REG_W-1:0]), .q(pulse_q)
  );
  cfg_word_reg #(.RESET(LENGTH_RST), .WMASK(ALL_WMASK)) u_length (
    .pclk(pclk), .presetn(presetn), .we(wr && idx == IDX_LENGTH),
    .strb(pstrb[1:0]), .wdata(pwdata[REG_W-1:0]), .q(length_q)
  );
  cfg_word_reg #(.RESET(SHORT_RST), .WMASK(ALL_WMASK)) u_short (
    .pclk(pclk), .presetn(presetn), .we(wr && idx == IDX_SHORT),
    .strb(pstrb[1:0]), .wdata(pwdata[REG_W-1:0]), .q(short_q)
  );
  cfg_word_reg #(.RESET({{(REG_W-IRQ_W){1'b0}}, IRQ_MASK_RST}), .WMASK({{(REG_W-IRQ_W){1'b0}}, {IRQ_W{1'b1}}})) u_mask (
    .pclk(pclk), .presetn(presetn), .we(wr && idx == IDX_IRQ_MASK),
    .strb(pstrb[1:0]), .wdata(pwdata[REG_W-1:0]), .q(mask_q)
  );

  always_comb begin
    tdr_cfg.cross_disable = ctrl_q[CROSS_DIS_BIT];
    tdr_cfg.bypass_tx = ctrl_q[BYP_TX_BIT];
    tdr_cfg.bypass_rx = ctrl_q[BYP_RX_BIT];
    tdr_cfg.avg_code = ctrl_q[AVG_LSB +: 3];
    tdr_cfg.pulse = pulse_q[PULSE_LSB +: 4];
    tdr_cfg.listen_len = length_q[LEN_LSB +: 8];
    tdr_cfg.short_thr = short_q[SHORT_LSB +: 5];
    // reserved code runs the longest average
    if (tdr_cfg.avg_code > AVG_MAX_CODE) begin
      tdr_avg_count = AVG_MAX_COUNT;
    end else begin
      tdr_avg_count = 7'(7'h01 << tdr_cfg.avg_code);
    end
  end

  // ---------------------------------------------------------------
  // active-link test control
  // ---------------------------------------------------------------
  active_link_cable_test_state_t active_link_cable_test_state;
  active_link_cable_test_state_t next_active_link_cable_test_state;
  logic active_link_cable_test_busy;
  logic next_active_link_cable_test_busy;
  logic next_active_link_cable_test_start;
  logic [7:0] next_sum;
  logic [3:0] active_link_cable_test_low;
  logic [3:0] next_active_link_cable_test_low;
  logic active_link_cable_test_go;
  logic active_link_cable_test_fin;
  assign active_link_cable_test_go = wr && idx == IDX_ACTIVE_LINK_CABLE_TEST && pstrb[1] && pwdata[ACTIVE_LINK_CABLE_TEST_START_BIT];
  assign active_link_cable_test_fin = active_link_cable_test_state == ACTIVE_LINK_CABLE_TEST_RUN && active_link_cable_test_res.done;

  always_comb begin
    next_active_link_cable_test_state = active_link_cable_test_state;
    next_active_link_cable_test_busy = active_link_cable_test_busy;
    next_active_link_cable_test_start = 1'b0;
    next_sum = active_link_summary_out;
    next_active_link_cable_test_low = active_link_cable_test_low;
    if (wr && idx == IDX_ACTIVE_LINK_CABLE_TEST && pstrb[0]) begin
      next_active_link_cable_test_low = pwdata[ACTIVE_LINK_CABLE_TEST_LOW_LSB +: 4];
    end
    unique case (active_link_cable_test_state)
      ACTIVE_LINK_CABLE_TEST_IDLE: begin
        if (active_link_cable_test_go) begin
          next_active_link_cable_test_state = ACTIVE_LINK_CABLE_TEST_RUN;
          next_active_link_cable_test_start = 1'b1;
          next_active_link_cable_test_busy = 1'b1;
        end
      end
      ACTIVE_LINK_CABLE_TEST_RUN: begin
        if (active_link_cable_test_res.done) begin
          next_active_link_cable_test_state = ACTIVE_LINK_CABLE_TEST_IDLE;
          next_active_link_cable_test_busy = 1'b0;
          next_sum = active_link_cable_test_res.sum;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_link_cable_test_state <= ACTIVE_LINK_CABLE_TEST_IDLE;
      active_link_cable_test_busy <= 1'b1;
      active_link_cable_test_start <= 1'b0;
      active_link_summary_out <= ACTIVE_LINK_CABLE_TEST_SUM_RST;
      active_link_cable_test_low <= ACTIVE_LINK_CABLE_TEST_LOW_RST;
    end else begin
      active_link_cable_test_state <= next_active_link_cable_test_state;
      active_link_cable_test_busy <= next_active_link_cable_test_busy;
      active_link_cable_test_start <= next_active_link_cable_test_start;
      active_link_summary_out <= next_sum;
      active_link_cable_test_low <= next_active_link_cable_test_low;
    end
  end

  // ---------------------------------------------------------------
  // peak results and interrupt status
  // ---------------------------------------------------------------
  logic [REG_W-1:0] loc1;
  logic [REG_W-1:0] next_loc1;
  logic [IRQ_W-1:0] irq_st;
  logic [IRQ_W-1:0] next_irq_st;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // results load only on a completion pulse
  always_comb begin
    next_loc1 = loc1;
    if (tdr_res.done) begin
      next_loc1 = {tdr_res.peak2, tdr_res.peak1};
    end
    irq_set = '0;
    irq_set[IRQ_ACTIVE_LINK_CABLE_TEST_BIT] = active_link_cable_test_fin;
    irq_set[IRQ_TDR_BIT] = tdr_res.done;
    irq_clr = '0;
    if (wr && idx == IDX_IRQ_STATUS && pstrb[0]) begin
      irq_clr = pwdata[IRQ_W-1:0];
    end
    // set wins over a clear in the same cycle
    next_irq_st = (irq_st & ~irq_clr) | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loc1 <= '0;
      irq_st <= '0;
    end else begin
      loc1 <= next_loc1;
      irq_st <= next_irq_st;
    end
  end

  assign irq = |(irq_st & mask_q[IRQ_W-1:0]);

  // ---------------------------------------------------------------
  // read data, captured in the setup cycle
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] next_prdata;
  logic [REG_W-1:0] rword;

  always_comb begin
    rword = '0;
    unique case (idx)
      IDX_ACTIVE_LINK_CABLE_TEST: begin
        rword[ACTIVE_LINK_CABLE_TEST_STATUS_BIT] = active_link_cable_test_busy;
        rword[ACTIVE_LINK_CABLE_TEST_SUM_LSB +: 8] = active_link_summary_out;
        rword[ACTIVE_LINK_CABLE_TEST_LOW_LSB +: 4] = active_link_cable_test_low;
      end
      IDX_CTRL: rword = ctrl_q;
      IDX_PULSE: rword = pulse_q;
      IDX_LENGTH: rword = length_q;
      IDX_SHORT: rword = short_q;
      IDX_LOC1: rword = loc1;
      IDX_IRQ_STATUS: rword[IRQ_W-1:0] = irq_st;
      IDX_IRQ_MASK: rword = mask_q;
      default: rword = '0;
    endcase
    next_prdata = prdata;
    if (setup && !pwrite) begin
      next_prdata = {{(DATA_W-REG_W){1'b0}}, rword};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // checks on launch, status, settings and results
  property p_start_pulse;
    @(posedge pclk) disable iff (!presetn)
      (active_link_cable_test_go && active_link_cable_test_state == ACTIVE_LINK_CABLE_TEST_IDLE) |=> active_link_cable_test_start ##1 !active_link_cable_test_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse missing");

  property p_no_start_zero;
    @(posedge pclk) disable iff (!presetn)
      !active_link_cable_test_go |=> !active_link_cable_test_start;
  endproperty
  a_no_start_zero: assert property (p_no_start_zero) else $error("spurious start");

  property p_busy_until_done;
    @(posedge pclk) disable iff (!presetn)
      (active_link_cable_test_busy && !active_link_cable_test_fin) |=> active_link_cable_test_busy;
  endproperty
  a_busy_until_done: assert property (p_busy_until_done) else $error("status cleared early");

  property p_done_clears;
    @(posedge pclk) disable iff (!presetn)
      active_link_cable_test_fin |=> !active_link_cable_test_busy && irq_st[IRQ_ACTIVE_LINK_CABLE_TEST_BIT];
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("status not cleared");

  property p_cross_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_CTRL && pstrb[1]) |=> tdr_cfg.cross_disable == $past(pwdata[CROSS_DIS_BIT]);
  endproperty
  a_cross_write: assert property (p_cross_write) else $error("cross disable wrong");

  property p_bypass_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_CTRL && pstrb[1]) |=>
        {tdr_cfg.bypass_tx, tdr_cfg.bypass_rx} == $past(pwdata[BYP_TX_BIT:BYP_RX_BIT]);
  endproperty
  a_bypass_write: assert property (p_bypass_write) else $error("bypass bits wrong");

  property p_avg_count;
    @(posedge pclk) disable iff (!presetn)
      tdr_cfg.avg_code == 3'h3 |-> tdr_avg_count == 7'h08;
  endproperty
  a_avg_count: assert property (p_avg_count) else $error("average count wrong");

  property p_reset_vals;
    @(posedge pclk) $rose(presetn) |->
      tdr_cfg.pulse == 4'hC && tdr_cfg.listen_len == 8'hFF && tdr_cfg.short_thr == 5'h18
      && tdr_cfg.avg_code == 3'h6 && active_link_cable_test_busy && loc1 == 16'h0000;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_peak_update;
    @(posedge pclk) disable iff (!presetn)
      tdr_res.done |=> loc1 == {$past(tdr_res.peak2), $past(tdr_res.peak1)};
  endproperty
  a_peak_update: assert property (p_peak_update) else $error("peaks not captured");

  property p_peak_hold;
    @(posedge pclk) disable iff (!presetn)
      !tdr_res.done |=> $stable(loc1);
  endproperty
  a_peak_hold: assert property (p_peak_hold) else $error("peaks changed without run");

  c_active_link_cable_test_run: cover property (@(posedge pclk) disable iff (!presetn) active_link_cable_test_start ##[1:20] active_link_cable_test_fin);
  c_tdr_done: cover property (@(posedge pclk) disable iff (!presetn) tdr_res.done);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  // reserved averaging code reached by software
  c_avg_reserved: cover property (@(posedge pclk) disable iff (!presetn) tdr_cfg.avg_code == 3'h7);
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the cable diagnostic register bank
// assumes cable_diag_pkg compiled first; bench drives APB and engine results itself
`default_nettype none
module tb
  import cable_diag_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic active_link_cable_test_start;
  active_link_cable_test_result_t active_link_cable_test_res = '0;
  tdr_result_t tdr_res = '0;
  tdr_cfg_t tdr_cfg;
  logic [6:0] tdr_avg_count;
  logic [7:0] active_link_summary_out;
  int err_total = 0;
  int n_compared = 0;
  int n_start = 0;
  logic [31:0] seed = 32'h465EE38A;
  logic [31:0] r;
  logic [31:0] v;
  logic e;
  logic [7:0] s;

  cable_diag_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .active_link_cable_test_start(active_link_cable_test_start), .active_link_cable_test_res(active_link_cable_test_res), .tdr_res(tdr_res), .tdr_cfg(tdr_cfg),
    .tdr_avg_count(tdr_avg_count), .active_link_summary_out(active_link_summary_out));

  always #10 pclk = ~pclk;

  // launch pulses seen, sampled mid-cycle
  always @(negedge pclk) begin
    if (active_link_cable_test_start === 1'b1) begin
      n_start++;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [6:0] exp_avg(input logic [2:0] code);
    return (code == 3'h7) ? 7'h40 : (7'h01 << code);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [9:0] idx, input logic [15:0] d, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [3:0] st);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, st, rd, err);
    // second negedge lets the launch-pulse counter settle first
    repeat (2) @(negedge pclk);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [31:0] expv);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 16'h0000, 4'h0, rd, err);
    chk(rd, expv);
    chk({31'h0, err}, 32'h0);
  endtask

  task automatic tdr_done(input logic [7:0] p1, input logic [7:0] p2);
    @(posedge pclk);
    tdr_res <= {1'b1, p1, p2};
    @(posedge pclk);
    tdr_res.done <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({9'h0, tdr_cfg}, {9'h0, 1'b0, 1'b0, 1'b0, 3'h6, 4'hC, 8'hFF, 5'h18});
    chk({25'h0, tdr_avg_count}, 32'h40);
    chk({24'h0, active_link_summary_out}, 32'hF4);
    rdc(IDX_ACTIVE_LINK_CABLE_TEST, 32'h1F41);
    rdc(IDX_CTRL, 32'h0E52);
    rdc(IDX_PULSE, 32'hC85C);
    rdc(IDX_LENGTH, 32'hFF1E);
    rdc(IDX_SHORT, 32'h189B);
    rdc(IDX_LOC1, 32'h0);
    // every averaging code with random neighbour bits
    for (int i = 0; i < 8; i++) begin
      r = xs();
      wr(IDX_CTRL, {r[15:11], i[2:0], r[7:0]}, 4'hF);
      chk({29'h0, tdr_cfg.avg_code}, i);
      chk({25'h0, tdr_avg_count}, {25'h0, exp_avg(i[2:0])});
      chk({31'h0, tdr_cfg.cross_disable}, {31'h0, r[14]});
      chk({31'h0, tdr_cfg.bypass_tx}, {31'h0, r[13]});
      chk({31'h0, tdr_cfg.bypass_rx}, {31'h0, r[12]});
      rdc(IDX_CTRL, {16'h0, 1'b0, r[14:11], i[2:0], r[7:0]});
      wr(IDX_PULSE, r[31:16], 4'hF);
      chk({28'h0, tdr_cfg.pulse}, {28'h0, r[19:16]});
      wr(IDX_LENGTH, r[15:0], 4'hF);
      chk({24'h0, tdr_cfg.listen_len}, {24'h0, r[15:8]});
      wr(IDX_SHORT, r[31:16], 4'hF);
      chk({27'h0, tdr_cfg.short_thr}, {27'h0, r[28:24]});
      rdc(IDX_SHORT, {16'h0, r[31:16]});
    end
    // low byte lane only
    wr(IDX_PULSE, 16'hABC3, 4'h1);
    rdc(IDX_PULSE, {16'h0, r[31:24], 8'hC3});
    // unmapped index answers with an error and zero
    apb(1'b0, 10'h3FF, 16'h0, 4'h0, v, e);
    chk(v, 32'h0);
    chk({31'h0, e}, 32'h1);
    // active-link test: zero launches nothing, one launches once
    wr(IDX_ACTIVE_LINK_CABLE_TEST, 16'h0005, 4'h3);
    chk(n_start, 0);
    rdc(IDX_ACTIVE_LINK_CABLE_TEST, 32'h1F45);
    wr(IDX_ACTIVE_LINK_CABLE_TEST, 16'h8003, 4'h3);
    chk(n_start, 1);
    rdc(IDX_ACTIVE_LINK_CABLE_TEST, 32'h1F43);
    wr(IDX_ACTIVE_LINK_CABLE_TEST, 16'h8003, 4'h3);
    chk(n_start, 1);
    r = xs();
    s = r[7:0];
    @(posedge pclk);
    active_link_cable_test_res <= {1'b1, s};
    @(posedge pclk);
    active_link_cable_test_res.done <= 1'b0;
    @(negedge pclk);
    chk({24'h0, active_link_summary_out}, {24'h0, s});
    rdc(IDX_ACTIVE_LINK_CABLE_TEST, {20'h0, s, 4'h3});
    rdc(IDX_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 16'h0001, 4'h1);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STATUS, 16'h0001, 4'h1);
    chk({31'h0, irq}, 32'h0);
    rdc(IDX_IRQ_STATUS, 32'h0);
    // reflectometry results update on completion and hold otherwise
    wr(IDX_IRQ_MASK, 16'h0002, 4'h1);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      tdr_done(r[7:0], r[15:8]);
      rdc(IDX_LOC1, {16'h0, r[15:8], r[7:0]});
      chk({31'h0, irq}, 32'h1);
      @(posedge pclk);
      tdr_res <= {1'b0, r[23:16], r[31:24]};
      rdc(IDX_LOC1, {16'h0, r[15:8], r[7:0]});
      wr(IDX_IRQ_STATUS, 16'h0002, 4'h1);
      chk({31'h0, irq}, 32'h0);
    end
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
